// ===== src/tsc_top.sv
// trigger, shutter delay and strobe controller with avalon-mm registers
//
// Operation
// - triggers, external or software, act only while trigger enable is set
// - mode selects standard, bulb or skip behaviour; other codes act standard
// - parameter sets the trigger cycle for skip mode
// - external trigger comes from the pin the source field selects
// - polarity field picks the falling or rising edge as the trigger event
// - with delay enabled, exposure starts after programmed delay from trigger
// - with triggering off, same delay acts as free-run shutter delay
// - each software trigger write with bit 0 set gives exactly one trigger event
// - each pin has its own input or output direction bit
// - source pin stays input while triggering is enabled
// - each pin can be enabled as a strobe output
// - strobe asserts with its polarity after delay from exposure start; at delay 0 with nonzero duration the code also repeats it between exposures
// - strobe delay counts clock ticks, range 0 to 4095
// - strobe duration counts clock ticks, range 0 to 4095
// - zero duration keeps strobe active from its delay until the exposure ends
// - strobe pattern mode is set only through registers
// - after reset the opto input pin 0 is the trigger source
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "tsc_defs.svh"

module tsc_top
    import tsc_pkg::*;
(
    input  wire logic                     clk_in,
    input  wire logic                     rst_b_in,
    input  wire logic [`TSC_ADDR_W-1:0]   avs_address_in,
    input  wire logic                     avs_read_in,
    input  wire logic                     avs_write_in,
    input  wire logic [31:0]              avs_writedata_in,
    input  wire logic [3:0]               avs_byteenable_in,
    output logic      [31:0]              avs_readdata_out,
    output logic                          avs_waitrequest_out,
    input  wire logic [`TSC_NPIN-1:0]     gpio_in,
    output logic      [`TSC_NPIN-1:0]     gpio_out,
    output logic      [`TSC_NPIN-1:0]     gpio_oe_out,
    output logic                          exposing_out
);
    logic [1:0]                rst_sync;
    logic                      rst_b;
    logic                      ack;
    logic                      wr_go;
    logic                      rd_go;
    tsc_trig_type              trig;
    tsc_strb_type              strb;
    logic [`TSC_DLY_W-1:0]     tdly;
    logic [`TSC_DLY_W-1:0]     explen;
    logic [`TSC_CNT_W-1:0]     sdly;
    logic [`TSC_CNT_W-1:0]     sdur;
    logic [`TSC_NPIN-1:0]      dir;
    logic [`TSC_NPIN-1:0]      lvl;
    logic [`TSC_NPIN-1:0]      dir_eff;
    logic                      sw_pulse;
    logic [`TSC_NPIN-1:0]      sync1;
    logic [`TSC_NPIN-1:0]      sync2;
    logic                      trig_lvl;
    logic                      trig_lvl_q;
    logic                      ext_edge;
    logic                      trig_evt;
    logic                      trig_start;
    logic [`TSC_CNT_W-1:0]     skip_cnt;
    tsc_state_type             state;
    logic [`TSC_DLY_W-1:0]     cnt;
    logic [`TSC_CNT_W:0]       str_cnt;
    logic                      strobe_act;
    logic                      pat_ok;
    logic [`TSC_PAT_IDX_W-1:0] pat_idx;
    logic [7:0]                trig_count;
    logic                      use_dly;
    logic                      start_exp;
    logic [31:0]               wmask;
    logic [31:0]               next_readdata;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'h1};
    end
    assign rst_b = rst_sync[1];

    // one wait cycle per access keeps read data registered
    assign wr_go = avs_write_in && ack;
    assign rd_go = avs_read_in;
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;
    assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
            ack <= 1'h0;
        else
            ack <= (avs_read_in || avs_write_in) && !ack;
    end

    // byte-lane merge of write data into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [31:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction

    // trigger configuration; source resets to opto input
    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trig     <= '0;
            trig.src <= `TSC_SRC_RESET;
            tdly     <= '0;
            explen   <= `TSC_EXPLEN_RESET;
        end
        else if (wr_go && avs_address_in == `TSC_OFF_TRIG)
        begin
            logic [31:0] w;
            w = merge({4'h0, trig.param, 8'h00, trig.delay_en, trig.src,
                       trig.pol, trig.mode, trig.en},
                      avs_writedata_in, wmask);
            trig.en       <= w[`TSC_TRIG_EN_B];
            trig.mode     <= w[`TSC_TRIG_MODE_HI:`TSC_TRIG_MODE_LO];
            trig.pol      <= w[`TSC_TRIG_POL_B];
            trig.src      <= w[`TSC_TRIG_SRC_HI:`TSC_TRIG_SRC_LO];
            trig.delay_en <= w[`TSC_TRIG_DEN_B];
            trig.param    <= w[`TSC_TRIG_PAR_HI:`TSC_TRIG_PAR_LO];
        end
        else if (wr_go && avs_address_in == `TSC_OFF_TDLY)
            tdly <= `TSC_DLY_W'(merge({16'h0000, tdly}, avs_writedata_in,
                                      wmask));
        else if (wr_go && avs_address_in == `TSC_OFF_EXPLEN)
            explen <= `TSC_DLY_W'(merge({16'h0000, explen},
                                        avs_writedata_in, wmask));
    end

    // software trigger: one pulse per accepted write with data bit 0 set
    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
            sw_pulse <= 1'h0;
        else
            sw_pulse <= wr_go && avs_address_in == `TSC_OFF_SWTRIG
                        && avs_byteenable_in[0]
                        && avs_writedata_in[0];
    end

    // pin direction and static output level
    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dir <= '0;
            lvl <= '0;
        end
        else if (wr_go && avs_address_in == `TSC_OFF_GPIO)
        begin
            logic [31:0] w;
            w = merge({20'h00000, lvl, 4'h0, dir}, avs_writedata_in, wmask);
            dir <= w[`TSC_GPIO_DIR_HI:`TSC_GPIO_DIR_LO];
            lvl <= w[`TSC_GPIO_LVL_HI:`TSC_GPIO_LVL_LO];
        end
    end

    // strobe configuration; counts above 4095 cannot be stored
    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strb <= '0;
            sdly <= '0;
            sdur <= '0;
        end
        else if (wr_go && avs_address_in == `TSC_OFF_STRB)
        begin
            logic [31:0] w;
            w = merge({strb.pattern, 7'h00, strb.pat_en, strb.pol, strb.en},
                      avs_writedata_in, wmask);
            strb.en      <= w[`TSC_STRB_EN_HI:`TSC_STRB_EN_LO];
            strb.pol     <= w[`TSC_STRB_POL_HI:`TSC_STRB_POL_LO];
            strb.pat_en  <= w[`TSC_STRB_PATEN_B];
            strb.pattern <= w[`TSC_STRB_PAT_HI:`TSC_STRB_PAT_LO];
        end
        else if (wr_go && avs_address_in == `TSC_OFF_SDLY)
            sdly <= `TSC_CNT_W'(merge({20'h00000, sdly}, avs_writedata_in,
                                      wmask));
        else if (wr_go && avs_address_in == `TSC_OFF_SDUR)
            sdur <= `TSC_CNT_W'(merge({20'h00000, sdur}, avs_writedata_in,
                                      wmask));
    end

    // read mux; unmapped offsets read zero
    always_comb
    begin
        next_readdata = 32'h00000000;
        case (avs_address_in)
            `TSC_OFF_TRIG:   next_readdata = {4'h0, trig.param, 8'h00,
                                trig.delay_en, trig.src, trig.pol,
                                trig.mode, trig.en};
            `TSC_OFF_TDLY:   next_readdata = {16'h0000, tdly};
            `TSC_OFF_GPIO:   next_readdata = {20'h00000, lvl, 4'h0, dir_eff};
            `TSC_OFF_STRB:   next_readdata = {strb.pattern, 7'h00,
                                strb.pat_en, strb.pol, strb.en};
            `TSC_OFF_SDLY:   next_readdata = {20'h00000, sdly};
            `TSC_OFF_SDUR:   next_readdata = {20'h00000, sdur};
            `TSC_OFF_EXPLEN: next_readdata = {16'h0000, explen};
            `TSC_OFF_STATUS: next_readdata = {16'h0000, trig_count,
                                sync2, strobe_act, exposing_out, 1'h0,
                                state != TSC_IDLE};
            default:         next_readdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
            avs_readdata_out <= 32'h00000000;
        else if (rd_go && !ack)
            avs_readdata_out <= next_readdata;
    end

    // two-flop synchroniser per pin; only stage two is looked at
    genvar gi;
    generate
        for (gi = 0; gi < `TSC_NPIN; gi++)
        begin : g_sync
            always_ff @(posedge clk_in or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    sync1[gi] <= 1'h0;
                    sync2[gi] <= 1'h0;
                end
                else
                begin
                    sync1[gi] <= gpio_in[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    // selected pin, polarity applied, then edge detect
    assign trig_lvl = sync2[trig.src] ~^ trig.pol;
    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
            trig_lvl_q <= 1'h0;
        else
            trig_lvl_q <= trig_lvl;
    end
    assign ext_edge = trig_lvl && !trig_lvl_q;
    assign trig_evt = trig.en && (ext_edge || sw_pulse);

    // skip mode starts only every param+1 trigger
    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
            skip_cnt <= '0;
        else if (trig.mode != `TSC_MODE_SKIP)
            skip_cnt <= '0;
        else if (trig_evt && state == TSC_IDLE)
            skip_cnt <= (skip_cnt >= trig.param) ? '0
                        : skip_cnt + 12'h001;
    end
    assign trig_start = trig_evt && (trig.mode != `TSC_MODE_SKIP
                        || skip_cnt >= trig.param);

    // acquisition sequencer; triggers during an exposure are dropped
    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= TSC_IDLE;
            cnt   <= '0;
        end
        else
        begin
            case (state)
                TSC_IDLE:
                    if (!trig.en || trig_start)
                    begin
                        // free run reuses the delay as shutter delay
                        if ((trig.delay_en || !trig.en)
                            && tdly != 16'h0000)
                        begin
                            state <= TSC_DELAY;
                            cnt   <= tdly - 16'h0001;
                        end
                        else
                        begin
                            state <= TSC_EXPOSE;
                            cnt   <= '0;
                        end
                    end
                TSC_DELAY:
                    if (cnt == 16'h0000)
                        state <= TSC_EXPOSE;
                    else
                        cnt <= cnt - 16'h0001;
                TSC_EXPOSE:
                    // bulb holds while the trigger level is active
                    if (trig.en && trig.mode == `TSC_MODE_BULB)
                    begin
                        if (!trig_lvl)
                            state <= TSC_IDLE;
                    end
                    else if (cnt + 16'h0001 >= explen)
                        state <= TSC_IDLE;
                    else
                        cnt <= cnt + 16'h0001;
                default:
                    state <= TSC_IDLE;
            endcase
        end
    end
    assign exposing_out = state == TSC_EXPOSE;

    // exposure entry, from idle with no delay or at the end of the delay
    assign use_dly   = (trig.delay_en || !trig.en) && tdly != 16'h0000;
    assign start_exp = (state == TSC_DELAY && cnt == 16'h0000)
                       || (state == TSC_IDLE && (!trig.en || trig_start)
                           && !use_dly);

    // strobe tick counter from exposure start, saturating
    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
            str_cnt <= '0;
        else if (!exposing_out && !strobe_act)
            str_cnt <= '0;
        else if (str_cnt != '1) // stops above any delay plus duration
            str_cnt <= str_cnt + 13'h0001;
    end

    // pattern index advances once per exposure
    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pat_idx    <= '0;
            trig_count <= '0;
        end
        else if (start_exp)
        begin
            pat_idx    <= pat_idx + 4'h1;
            trig_count <= trig_count + 8'h01;
        end
    end
    assign pat_ok = !strb.pat_en || strb.pattern[pat_idx];

    // duration zero tracks exposure; otherwise a fixed tick window
    assign strobe_act = pat_ok && ({1'h0, sdly} <= str_cnt)
                        && ((sdur == 12'h000) ? exposing_out
                           : (str_cnt < {1'h0, sdly} + {1'h0, sdur}))
                        && (exposing_out || sdur != 12'h000);

    // source pin forced to input while triggering is enabled
    generate
        for (gi = 0; gi < `TSC_NPIN; gi++)
        begin : g_pin
            assign dir_eff[gi] = dir[gi] && !(trig.en
                                 && trig.src == `TSC_SRC_W'(gi));
            always_ff @(posedge clk_in or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    gpio_out[gi]    <= 1'h0;
                    gpio_oe_out[gi] <= 1'h0;
                end
                else
                begin
                    gpio_oe_out[gi] <= dir_eff[gi];
                    gpio_out[gi]    <= strb.en[gi]
                        ? (strobe_act ~^ strb.pol[gi])
                        : lvl[gi];
                end
            end
        end
    endgenerate

    sequence seq_idle_no_trig;
        state == TSC_IDLE && trig.en && !trig_start;
    endsequence

    sequence seq_delay_done;
        state == TSC_DELAY && cnt == 16'h0000;
    endsequence

    trig_gate_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        seq_idle_no_trig |=> state == TSC_IDLE)
        else $error("left idle without an enabled trigger");

    sw_single_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        sw_pulse |=> !sw_pulse)
        else $error("software trigger lasted more than one cycle");

    src_input_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        trig.en |-> !dir_eff[trig.src])
        else $error("trigger source pin set as output");

    delay_end_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        seq_delay_done |=> state == TSC_EXPOSE)
        else $error("exposure did not follow expired delay");

    free_run_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        (state == TSC_IDLE && !trig.en && tdly == 16'h0003)
        |=> state == TSC_DELAY ##1 state == TSC_DELAY ##1 state == TSC_DELAY
        ##1 state == TSC_EXPOSE)
        else $error("shutter delay not applied in free run");

    edge_once_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        ext_edge |=> !ext_edge)
        else $error("external trigger edge repeated");

    strobe_early_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        strobe_act |-> str_cnt >= {1'h0, sdly})
        else $error("strobe before its delay");

    strobe_zero_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        (sdur == 12'h000 && sdly == 12'h000 && !strb.pat_en)
        |-> strobe_act == exposing_out)
        else $error("zero duration strobe does not follow exposure");

    reset_src_a: assert property (@(posedge clk_in) disable iff (!rst_b)
        $rose(rst_b) |-> trig.src == `TSC_SRC_RESET)
        else $error("trigger source not opto input after reset");
endmodule // tsc_top

// ===== src/tsc_defs.svh
// register offsets, field positions, reset values and widths for tsc
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH
`define TSC_ADDR_W        6
`define TSC_NPIN          4
`define TSC_SRC_W         2
`define TSC_CNT_W         12
`define TSC_DLY_W         16
`define TSC_OFF_TRIG      6'h00
`define TSC_OFF_TDLY      6'h04
`define TSC_OFF_SWTRIG    6'h08
`define TSC_OFF_GPIO      6'h0C
`define TSC_OFF_STRB      6'h10
`define TSC_OFF_SDLY      6'h14
`define TSC_OFF_SDUR      6'h18
`define TSC_OFF_EXPLEN    6'h1C
`define TSC_OFF_STATUS    6'h20
`define TSC_TRIG_EN_B     0
`define TSC_TRIG_MODE_LO  1
`define TSC_TRIG_MODE_HI  3
`define TSC_TRIG_POL_B    4
`define TSC_TRIG_SRC_LO   5
`define TSC_TRIG_SRC_HI   6
`define TSC_TRIG_DEN_B    7
`define TSC_TRIG_PAR_LO   16
`define TSC_TRIG_PAR_HI   27
`define TSC_GPIO_DIR_LO   0
`define TSC_GPIO_DIR_HI   3
`define TSC_GPIO_LVL_LO   8
`define TSC_GPIO_LVL_HI   11
`define TSC_STRB_EN_LO    0
`define TSC_STRB_EN_HI    3
`define TSC_STRB_POL_LO   4
`define TSC_STRB_POL_HI   7
`define TSC_STRB_PATEN_B  8
`define TSC_STRB_PAT_LO   16
`define TSC_STRB_PAT_HI   31
`define TSC_PAT_IDX_W     4
`define TSC_SRC_RESET     2'h0
`define TSC_EXPLEN_RESET  16'h0100
`define TSC_MODE_STD      3'h0
`define TSC_MODE_BULB     3'h1
`define TSC_MODE_SKIP     3'h2
`endif

// ===== src/tsc_pkg.sv
// types shared by the trigger and strobe controller
package tsc_pkg;
    typedef enum logic [1:0] {
        TSC_IDLE,
        TSC_DELAY,
        TSC_EXPOSE
    } tsc_state_type;

    // trigger configuration as one carrier
    typedef struct packed {
        logic [11:0] param;
        logic        delay_en;
        logic [1:0]  src;
        logic        pol;
        logic [2:0]  mode;
        logic        en;
    } tsc_trig_type;

    // strobe configuration as one carrier
    typedef struct packed {
        logic [15:0] pattern;
        logic        pat_en;
        logic [3:0]  pol;
        logic [3:0]  en;
    } tsc_strb_type;
endpackage : tsc_pkg

// ===== verification/tsc_far_side.sv
// trigger source and strobe load model on the general-purpose pins
`timescale 1ns/1ps
`include "tsc_defs.svh"

module tsc_far_side
(
    input  wire logic                 clk_in,
    input  wire logic [`TSC_NPIN-1:0] pin_drv_in,
    input  wire logic [`TSC_NPIN-1:0] pin_oe_in,
    output logic      [`TSC_NPIN-1:0] pin_lvl_out
);
    logic [`TSC_NPIN-1:0] ext = 4'h0;
    time                  fire_t = 0;

    // wire level: the device wins wherever it drives, else the source
    assign pin_lvl_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & ext);

    // park a source line at its inactive level between events
    task automatic idle(input int pin, input logic lvl);
        @(posedge clk_in);
        ext[pin] <= lvl;
    endtask

    // one trigger event held long enough to cross the synchroniser
    task automatic pulse(input int pin, input logic act, input int hold);
        @(posedge clk_in);
        ext[pin] <= act;
        fire_t = $time;
        repeat (hold) @(posedge clk_in);
        ext[pin] <= ~act;
    endtask
endmodule // tsc_far_side

// ===== verification/test_trigger_strobe_control.sv
// self-checking bench for the trigger and strobe controller
`timescale 1ns/1ps
`include "tsc_defs.svh"

module test_trigger_strobe_control
    import tsc_pkg::*;
;
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    wire  [31:0] rdata;
    wire         wreq;
    wire  [3:0]  gpio_in;
    wire  [3:0]  gpio_out;
    wire  [3:0]  gpio_oe;
    wire         exposing;
    int          bad_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          lat, elen, soff, slen, d, sdly, sdur, c0, p1, p2;
    time         rise_q[$];
    logic        prev_exp = 1'b0;
    logic        tp, sp;
    logic [31:0] rd;

    always #2 clk_in = ~clk_in;

    tsc_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .avs_address_in(avs_address), .avs_read_in(avs_read),
        .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe_out(gpio_oe),
        .exposing_out(exposing));

    tsc_far_side part (.clk_in(clk_in), .pin_drv_in(gpio_out),
        .pin_oe_in(gpio_oe), .pin_lvl_out(gpio_in));

    task automatic close_out();
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // cycle count, hang limit and log of exposure starts
    always @(posedge clk_in)
    begin
        cyc++;
        if (exposing === 1'b1 && prev_exp !== 1'b1)
            rise_q.push_back($time);
        prev_exp = exposing;
        if (cyc == 20000)
        begin
            bad_count++;
            close_out();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] wd);
        @(posedge clk_in);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= ~w;
        do @(posedge clk_in); while (wreq !== 1'b0);
        rd = rdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // find the next exposure start, then profile exposure and strobe
    task automatic measure(input int spin, input logic sact);
        time tr;
        while (exposing !== 1'b1) @(posedge clk_in);
        tr = $time;
        lat = int'((tr - part.fire_t) / 4);
        elen = 0;
        slen = 0;
        soff = -1;
        repeat (40)
        begin
            if (exposing === 1'b1) elen++;
            if (gpio_out[spin] === sact)
            begin
                if (soff < 0) soff = int'(($time - tr) / 4);
                slen++;
            end
            @(posedge clk_in);
        end
    endtask

    initial
    begin
        void'($urandom(99915));
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rd_chk(`TSC_OFF_TRIG, 32'h0);
        rd_chk(`TSC_OFF_EXPLEN, 32'h100);
        rd_chk(6'h24, 32'h0);
        bus(1'b1, `TSC_OFF_SDLY, 32'hFFFF);
        rd_chk(`TSC_OFF_SDLY, 32'hFFF);
        bus(1'b1, `TSC_OFF_SDUR, 32'hFFFF);
        rd_chk(`TSC_OFF_SDUR, 32'hFFF);
        bus(1'b1, `TSC_OFF_EXPLEN, 32'h8);
        bus(1'b1, `TSC_OFF_GPIO, 32'h4);
        bus(1'b1, `TSC_OFF_TRIG, 32'h31);
        repeat (300) @(posedge clk_in);
        // source pin must refuse the output direction while armed
        bus(1'b1, `TSC_OFF_GPIO, 32'hF);
        rd_chk(`TSC_OFF_GPIO, 32'hD);
        repeat (2) @(posedge clk_in);
        check(gpio_oe[1], 1'b0);
        check(gpio_oe[3], 1'b1);
        bus(1'b1, `TSC_OFF_GPIO, 32'h4);
        // random delays, strobe timing and both polarities
        for (int i = 0; i < 6; i++)
        begin
            d = $urandom % 8;
            sdly = (i == 2) ? 0 : $urandom % 4;
            sdur = (i == 2) ? 0 : $urandom % 4 + 1;
            tp = (i < 3);
            sp = i[0];
            bus(1'b1, `TSC_OFF_TDLY, 32'(d));
            bus(1'b1, `TSC_OFF_SDLY, 32'(sdly));
            bus(1'b1, `TSC_OFF_SDUR, 32'(sdur));
            bus(1'b1, `TSC_OFF_STRB, (32'(sp) << 6) | 32'h4);
            bus(1'b1, `TSC_OFF_TRIG, 32'hA1 | (32'(tp) << 4));
            part.idle(1, ~tp);
            repeat (40) @(posedge clk_in);
            fork
                part.pulse(1, tp, 4);
                measure(2, sp);
            join
            check(32'(lat >= 3 + d && lat <= 5 + d), 32'h1);
            check(32'(elen), 32'h8);
            check(32'(soff), 32'(sdly + 1));
            check(32'(slen), 32'(sdur == 0 ? 8 : sdur));
        end
        // one software trigger gives one exposure
        bus(1'b0, `TSC_OFF_STATUS, 32'h0);
        c0 = int'(rd[15:8]);
        bus(1'b1, `TSC_OFF_SWTRIG, 32'h1);
        measure(2, sp);
        check(32'(elen), 32'h8);
        bus(1'b0, `TSC_OFF_STATUS, 32'h0);
        check(32'(rd[15:8]), 32'((c0 + 1) % 256));
        // skip mode with parameter 1 takes every second event
        bus(1'b1, `TSC_OFF_TRIG, 32'h10035);
        part.idle(1, 1'b0);
        repeat (40) @(posedge clk_in);
        c0 = rise_q.size();
        repeat (4)
        begin
            part.pulse(1, 1'b1, 4);
            repeat (40) @(posedge clk_in);
        end
        check(32'(rise_q.size() - c0), 32'h2);
        // bulb mode follows the trigger level
        bus(1'b1, `TSC_OFF_TRIG, 32'h33);
        fork
            part.pulse(1, 1'b1, 20);
            measure(2, sp);
        join
        check(32'(elen >= 19 && elen <= 21), 32'h1);
        // free run: the period grows by the change in shutter delay
        bus(1'b1, `TSC_OFF_TRIG, 32'h0);
        bus(1'b1, `TSC_OFF_TDLY, 32'h3);
        repeat (60) @(posedge clk_in);
        p1 = int'((rise_q[$] - rise_q[$-1]) / 4);
        bus(1'b1, `TSC_OFF_TDLY, 32'hB);
        repeat (80) @(posedge clk_in);
        p2 = int'((rise_q[$] - rise_q[$-1]) / 4);
        check(32'(p2 - p1), 32'h8);
        // pattern mode with an all-zero pattern blocks every strobe
        bus(1'b1, `TSC_OFF_STRB, 32'h144);
        measure(2, 1'b1);
        check(32'(slen), 32'h0);
        close_out();
    end
endmodule // test_trigger_strobe_control
